// *** hdl/rstsys_pkg.sv ***
/*
  Constants for the reset source capture and system options block:
  register indices, field positions, reset values and timing counts.
  Assumes a 100 MHz bus clock and an 8-bit register port.
*/
package rstsys_pkg;

  // Register indices on the register port
  localparam logic [1:0] IDX_STATUS  = 2'h0;
  localparam logic [1:0] IDX_FORCE   = 2'h1;
  localparam logic [1:0] IDX_OPTIONS = 2'h2;

  // Reset cause status field positions
  localparam int POR_BIT    = 7;
  localparam int PIN_BIT    = 6;
  localparam int WDOG_BIT   = 5;
  localparam int ILLOP_BIT  = 4;
  localparam int CLKGEN_BIT = 2;
  localparam int LOWV_BIT   = 1;

  // Forced reset field position
  localparam int FORCE_BIT = 0;

  // System options field positions
  localparam int OPT_WDOG_EN  = 7;
  localparam int OPT_WDOG_LEN = 6;
  localparam int OPT_STOP_EN  = 5;
  localparam int OPT_DBG_EN   = 1;
  localparam int OPT_RST_EN   = 0;

  localparam logic [7:0] STATUS_POR_VALUE = 8'h82;
  localparam logic [7:0] ZERO_BYTE        = 8'h00;

  localparam logic WDOG_EN_RESET  = 1'b1;
  localparam logic WDOG_LEN_RESET = 1'b1;
  localparam logic STOP_EN_RESET  = 1'b0;
  localparam logic DBG_EN_RESET   = 1'b1;
  localparam logic RST_EN_POR     = 1'b0;

  // Least time the internal reset is held, and its count of cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int HOLD_TIME_NS  = 40;
  localparam int HOLD_CYCLES   =
    (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] HOLD_COUNT = 4'(HOLD_CYCLES - 1);

  typedef enum logic {SEQ_RUN, SEQ_HOLD} seq_state_t;

endpackage

// *** hdl/reset_source_and_system_options.sv ***
/*
  Reset source capture, debug forced reset and write-once system options.
  Assumes a single 100 MHz clock, rst_n as the power-on reset, and all
  reset source inputs synchronous to mclk. Read data is registered.
*/
`timescale 1ns/10ps
module reset_source_and_system_options
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [1:0] reg_index,
  input  wire logic       reg_write,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_from_debug,
  output logic      [7:0] reg_rdata,
  input  wire logic       reset_terminal_n,
  input  wire logic       low_voltage_below,
  input  wire logic       low_voltage_detect_enable,
  input  wire logic       low_voltage_reset_enable,
  input  wire logic       low_voltage_stop_enable,
  input  wire logic       stop_mode,
  input  wire logic       watchdog_timeout,
  input  wire logic       illegal_opcode,
  input  wire logic       stop_instruction,
  input  wire logic       background_instruction,
  input  wire logic       background_mode_enable,
  input  wire logic       clock_generator_reset,
  input  wire logic       watchdog_clock_select,
  output logic            system_reset,
  output logic            watchdog_restart,
  output logic            watchdog_enable,
  output logic      [1:0] watchdog_period_code,
  output logic            stop_enable,
  output logic            debug_terminal_enable,
  output logic            reset_terminal_enable
);

  rstsys_pkg::seq_state_t state;
  rstsys_pkg::seq_state_t next_state;
  logic [7:0] status;
  logic [7:0] next_status;
  logic [7:0] pending;
  logic [7:0] next_pending;
  logic [3:0] hold_cnt;
  logic [3:0] next_hold_cnt;
  logic       next_system_reset;
  logic       wdog_len;
  logic       next_wdog_en;
  logic       next_wdog_len;
  logic       next_stop_en;
  logic       next_dbg_en;
  logic       next_rst_en;
  logic       written;
  logic       next_written;
  logic [1:0] next_period_code;
  logic [7:0] next_rdata;
  logic       next_restart;
  logic       lv_active;
  logic       pin_active;
  logic       illegal_hit;
  logic       wdog_hit;
  logic       force_hit;
  logic [7:0] src_bits;
  logic       in_run;

  assign in_run = (state == rstsys_pkg::SEQ_RUN);

  // Reset sources as seen this cycle
  always_comb
  begin
    lv_active   = low_voltage_detect_enable & low_voltage_reset_enable
                & low_voltage_below
                & (~stop_mode | low_voltage_stop_enable);
    pin_active  = reset_terminal_enable & ~reset_terminal_n;
    illegal_hit = illegal_opcode
                | (stop_instruction & ~stop_enable)
                | (background_instruction
                   & ~background_mode_enable);
    wdog_hit    = watchdog_timeout & watchdog_enable;
    force_hit   = reg_write & reg_from_debug
                & (reg_index == rstsys_pkg::IDX_FORCE)
                & reg_wdata[rstsys_pkg::FORCE_BIT];
    src_bits    = rstsys_pkg::ZERO_BYTE;
    src_bits[rstsys_pkg::PIN_BIT]    = pin_active;
    src_bits[rstsys_pkg::WDOG_BIT]   = wdog_hit;
    src_bits[rstsys_pkg::ILLOP_BIT]  = illegal_hit;
    src_bits[rstsys_pkg::CLKGEN_BIT] = clock_generator_reset;
    src_bits[rstsys_pkg::LOWV_BIT]   = lv_active;
  end

  // Reset sequencer and cause capture
  always_comb
  begin
    next_state    = state;
    next_pending  = pending;
    next_hold_cnt = hold_cnt;
    next_status   = status;
    unique case (state)
      rstsys_pkg::SEQ_RUN:
      begin
        if ((|src_bits) | force_hit)
        begin
          next_state    = rstsys_pkg::SEQ_HOLD;
          next_hold_cnt = rstsys_pkg::HOLD_COUNT;
          // Forced reset alone leaves every flag clear
          next_pending  = src_bits;
          next_pending[rstsys_pkg::POR_BIT] =
            lv_active & status[rstsys_pkg::POR_BIT];
        end
      end
      rstsys_pkg::SEQ_HOLD:
      begin
        next_pending = pending | src_bits;
        next_pending[rstsys_pkg::POR_BIT] = pending[rstsys_pkg::POR_BIT];
        if (hold_cnt != 4'h0)
        begin
          next_hold_cnt = hold_cnt - 4'h1;
        end
        else if (~pin_active & ~lv_active)
        begin
          next_state  = rstsys_pkg::SEQ_RUN;
          next_status = pending;
        end
      end
    endcase
    next_system_reset = (next_state == rstsys_pkg::SEQ_HOLD);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state        <= rstsys_pkg::SEQ_HOLD;
      pending      <= rstsys_pkg::STATUS_POR_VALUE;
      status       <= rstsys_pkg::STATUS_POR_VALUE;
      hold_cnt     <= rstsys_pkg::HOLD_COUNT;
      system_reset <= 1'b1;
    end
    else
    begin
      state        <= next_state;
      pending      <= next_pending;
      status       <= next_status;
      hold_cnt     <= next_hold_cnt;
      system_reset <= next_system_reset;
    end
  end

  // Write-once system options
  always_comb
  begin
    next_wdog_en  = watchdog_enable;
    next_wdog_len = wdog_len;
    next_stop_en  = stop_enable;
    next_dbg_en   = debug_terminal_enable;
    next_rst_en   = reset_terminal_enable;
    next_written  = written;
    if (!in_run)
    begin
      next_wdog_en  = rstsys_pkg::WDOG_EN_RESET;
      next_wdog_len = rstsys_pkg::WDOG_LEN_RESET;
      next_stop_en  = rstsys_pkg::STOP_EN_RESET;
      next_dbg_en   = rstsys_pkg::DBG_EN_RESET;
      next_written  = 1'b0;
    end
    else if (reg_write & (reg_index == rstsys_pkg::IDX_OPTIONS)
             & ~written)
    begin
      next_wdog_en  = reg_wdata[rstsys_pkg::OPT_WDOG_EN];
      next_wdog_len = reg_wdata[rstsys_pkg::OPT_WDOG_LEN];
      next_stop_en  = reg_wdata[rstsys_pkg::OPT_STOP_EN];
      next_dbg_en   = reg_wdata[rstsys_pkg::OPT_DBG_EN];
      // Once set, only power-on clears the reset terminal
      next_rst_en   = reset_terminal_enable
                    | reg_wdata[rstsys_pkg::OPT_RST_EN];
      next_written  = 1'b1;
    end
    next_period_code = {watchdog_clock_select, wdog_len};
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      watchdog_enable       <= rstsys_pkg::WDOG_EN_RESET;
      wdog_len              <= rstsys_pkg::WDOG_LEN_RESET;
      stop_enable           <= rstsys_pkg::STOP_EN_RESET;
      debug_terminal_enable <= rstsys_pkg::DBG_EN_RESET;
      reset_terminal_enable <= rstsys_pkg::RST_EN_POR;
      written               <= 1'b0;
      watchdog_period_code  <= 2'h0;
    end
    else
    begin
      watchdog_enable       <= next_wdog_en;
      wdog_len              <= next_wdog_len;
      stop_enable           <= next_stop_en;
      debug_terminal_enable <= next_dbg_en;
      reset_terminal_enable <= next_rst_en;
      written               <= next_written;
      watchdog_period_code  <= next_period_code;
    end
  end

  // Register read path and watchdog restart
  always_comb
  begin
    next_rdata = rstsys_pkg::ZERO_BYTE;
    unique case (reg_index)
      rstsys_pkg::IDX_STATUS:  next_rdata = status;
      rstsys_pkg::IDX_FORCE:   next_rdata = rstsys_pkg::ZERO_BYTE;
      rstsys_pkg::IDX_OPTIONS:
        next_rdata = {watchdog_enable, wdog_len, stop_enable, 3'h0,
                      debug_terminal_enable, reset_terminal_enable};
      default:                 next_rdata = rstsys_pkg::ZERO_BYTE;
    endcase
    next_restart = in_run & reg_write
                 & (reg_index == rstsys_pkg::IDX_STATUS);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata        <= rstsys_pkg::ZERO_BYTE;
      watchdog_restart <= 1'b0;
    end
    else
    begin
      reg_rdata        <= next_rdata;
      watchdog_restart <= next_restart;
    end
  end

  property p_status_stable;
    @(posedge mclk) disable iff (!rst_n)
    in_run && $past(in_run) |-> status == $past(status);
  endproperty
  a_status_stable: assert property (p_status_stable)
    else $error("status changed while running");

  property p_status_write;
    @(posedge mclk) disable iff (!rst_n)
    in_run && reg_write && reg_index == rstsys_pkg::IDX_STATUS
      |=> watchdog_restart && $stable(status);
  endproperty
  a_status_write: assert property (p_status_write)
    else $error("status write did not restart watchdog");

  property p_force_alone;
    @(posedge mclk) disable iff (!rst_n)
    in_run && force_hit && src_bits == 8'h00
      |=> system_reset && pending == 8'h00;
  endproperty
  a_force_alone: assert property (p_force_alone)
    else $error("forced reset set a flag or did not reset");

  property p_user_force_ignored;
    @(posedge mclk) disable iff (!rst_n)
    in_run && reg_write && !reg_from_debug && src_bits == 8'h00
      |=> !system_reset;
  endproperty
  a_user_force_ignored: assert property (p_user_force_ignored)
    else $error("user write caused a reset");

  property p_force_reads_zero;
    @(posedge mclk) disable iff (!rst_n)
    reg_index == rstsys_pkg::IDX_FORCE |=> reg_rdata == 8'h00;
  endproperty
  a_force_reads_zero: assert property (p_force_reads_zero)
    else $error("forced reset register read nonzero");

  property p_options_once;
    @(posedge mclk) disable iff (!rst_n)
    in_run && written && reg_write
      && reg_index == rstsys_pkg::IDX_OPTIONS
      |=> $stable(watchdog_enable) && $stable(stop_enable)
          && $stable(debug_terminal_enable);
  endproperty
  a_options_once: assert property (p_options_once)
    else $error("second options write was honoured");

  property p_stop_illegal;
    @(posedge mclk) disable iff (!rst_n)
    in_run && stop_instruction && !stop_enable && !lv_active
      |=> system_reset && pending[4] && !pending[7];
  endproperty
  a_stop_illegal: assert property (p_stop_illegal)
    else $error("disabled stop did not give illegal reset");

  property p_lv_needs_enable;
    @(posedge mclk) disable iff (!rst_n)
    in_run && !low_voltage_reset_enable && !force_hit
      && !pin_active && !wdog_hit && !illegal_hit
      && !clock_generator_reset |=> !system_reset;
  endproperty
  a_lv_needs_enable: assert property (p_lv_needs_enable)
    else $error("low-voltage reset without its enable");

  property p_defaults_after_reset;
    @(posedge mclk) disable iff (!rst_n)
    $fell(system_reset) |-> watchdog_enable && debug_terminal_enable
      && !stop_enable && !written;
  endproperty
  a_defaults_after_reset: assert property (p_defaults_after_reset)
    else $error("options not at defaults after reset");

  property p_rst_terminal_sticky;
    @(posedge mclk) disable iff (!rst_n)
    reset_terminal_enable |=> reset_terminal_enable;
  endproperty
  a_rst_terminal_sticky: assert property (p_rst_terminal_sticky)
    else $error("reset terminal enable cleared without power-on");

  property p_pin_reset;
    @(posedge mclk) disable iff (!rst_n)
    in_run && pin_active |=> system_reset && pending[6];
  endproperty
  a_pin_reset: assert property (p_pin_reset)
    else $error("terminal reset not captured");

endmodule

// *** sim/debug_host_model.sv ***
/*
  Debug host partner: sends a force reset write over the debug link.
  Assumes the bench merges its request onto the register port.
*/
`timescale 1ns/10ps
module debug_host_model
(
  input  wire logic       mclk,
  input  wire logic       go,
  input  wire logic [3:0] delay,
  output logic            host_write,
  output logic      [1:0] host_index,
  output logic      [7:0] host_wdata
);
  initial
  begin
    host_write = 1'b0;
    host_index = 2'h3;
    host_wdata = 8'h00;
    forever
    begin
      @(posedge go);
      repeat (delay) @(negedge mclk);
      @(negedge mclk);
      host_write = 1'b1;
      host_index = rstsys_pkg::IDX_FORCE;
      host_wdata = 8'h01;
      @(negedge mclk);
      // Released lines show no stale value
      host_write = 1'b0;
      host_index = ~host_index;
      host_wdata = ~host_wdata;
    end
  end
endmodule

// *** sim/reset_source_and_system_options_test.sv ***
/*
  Self-checking bench for reset source capture and system options.
  Assumes the debug host model drives the debug side of the port.
*/
`timescale 1ns/10ps
module reset_source_and_system_options_test;
  logic       mclk, rst_n, tb_write, go, watchdog_clock_select;
  logic [1:0] tb_index, reg_index, host_index, watchdog_period_code;
  logic [7:0] tb_wdata, reg_wdata, host_wdata, reg_rdata, v;
  logic [3:0] host_delay;
  logic       reg_write, reg_from_debug, host_write, reset_terminal_n;
  logic       low_voltage_below, low_voltage_detect_enable, stop_mode;
  logic       low_voltage_reset_enable, low_voltage_stop_enable;
  logic       watchdog_timeout, illegal_opcode, stop_instruction;
  logic       background_instruction, background_mode_enable;
  logic       clock_generator_reset, system_reset, watchdog_restart;
  logic       watchdog_enable, stop_enable, debug_terminal_enable;
  logic       reset_terminal_enable;
  int         fails, num_checks, cycles;

  assign reg_write = tb_write | host_write;
  assign reg_index = host_write ? host_index : tb_index;
  assign reg_wdata = host_write ? host_wdata : tb_wdata;
  assign reg_from_debug = host_write;

  debug_host_model debug_host_model_inst
  (
    .mclk(mclk), .go(go), .delay(host_delay), .host_write(host_write),
    .host_index(host_index), .host_wdata(host_wdata)
  );

  reset_source_and_system_options reset_source_and_system_options_inst
  (
    .mclk(mclk), .rst_n(rst_n), .reg_index(reg_index),
    .reg_write(reg_write), .reg_wdata(reg_wdata),
    .reg_from_debug(reg_from_debug), .reg_rdata(reg_rdata),
    .reset_terminal_n(reset_terminal_n),
    .low_voltage_below(low_voltage_below),
    .low_voltage_detect_enable(low_voltage_detect_enable),
    .low_voltage_reset_enable(low_voltage_reset_enable),
    .low_voltage_stop_enable(low_voltage_stop_enable),
    .stop_mode(stop_mode), .watchdog_timeout(watchdog_timeout),
    .illegal_opcode(illegal_opcode), .stop_instruction(stop_instruction),
    .background_instruction(background_instruction),
    .background_mode_enable(background_mode_enable),
    .clock_generator_reset(clock_generator_reset),
    .watchdog_clock_select(watchdog_clock_select),
    .system_reset(system_reset), .watchdog_restart(watchdog_restart),
    .watchdog_enable(watchdog_enable),
    .watchdog_period_code(watchdog_period_code),
    .stop_enable(stop_enable),
    .debug_terminal_enable(debug_terminal_enable),
    .reset_terminal_enable(reset_terminal_enable)
  );

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    begin
      num_checks++;
      if (seen !== exp)
      begin
        fails++;
        $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask

  task automatic wrap_up;
    begin
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      wrap_up;
    end
  end

  task automatic wr(input logic [1:0] idx, input logic [7:0] d);
    begin
      @(negedge mclk);
      tb_index = idx;
      tb_wdata = d;
      tb_write = 1'b1;
      @(negedge mclk);
      tb_write = 1'b0;
    end
  endtask

  task automatic rd(input logic [1:0] idx, output logic [7:0] d);
    begin
      @(negedge mclk);
      tb_index = idx;
      @(negedge mclk);
      d = reg_rdata;
    end
  endtask

  // Waits for the internal reset to drop, then one idle cycle
  task automatic settle;
    int n;
    begin
      n = 0;
      while (system_reset !== 1'b0 && n < 20)
      begin
        @(negedge mclk);
        n++;
      end
      check("reset release", {7'h0, system_reset}, 8'h00);
      @(negedge mclk);
    end
  endtask

  task automatic por;
    begin
      @(negedge mclk);
      rst_n = 1'b0;
      repeat (4) @(negedge mclk);
      rst_n = 1'b1;
      settle;
    end
  endtask

  task automatic opts(input logic [7:0] exp);
    begin
      rd(rstsys_pkg::IDX_OPTIONS, v);
      check("options", v, exp);
      check("wdog_en", {7'h0, watchdog_enable}, {7'h0, exp[7]});
      check("stop_en", {7'h0, stop_enable}, {7'h0, exp[5]});
      check("dbg_en", {7'h0, debug_terminal_enable}, {7'h0, exp[1]});
      check("rst_en", {7'h0, reset_terminal_enable}, {7'h0, exp[0]});
      check("period", {6'h0, watchdog_period_code},
            {6'h0, watchdog_clock_select, exp[6]});
    end
  endtask

  task automatic restart_chk(input logic [7:0] exp);
    int n;
    begin
      n = 0;
      wr(rstsys_pkg::IDX_STATUS, 8'hFF);
      repeat (3)
      begin
        if (watchdog_restart === 1'b1)
          n++;
        @(negedge mclk);
      end
      check("restart pulses", 8'(n), 8'h01);
      rd(rstsys_pkg::IDX_STATUS, v);
      check("status kept", v, exp);
    end
  endtask

  // Raises one reset source, then judges reset and captured status
  task automatic fire(input int src, input logic hit, input logic [7:0] exp);
    logic seen;
    begin
      seen = 1'b0;
      @(negedge mclk);
      case (src)
        0: watchdog_timeout = 1'b1;
        1: illegal_opcode = 1'b1;
        2: stop_instruction = 1'b1;
        3: background_instruction = 1'b1;
        4: clock_generator_reset = 1'b1;
        5: low_voltage_below = 1'b1;
        6: reset_terminal_n = 1'b0;
        7: {tb_index, tb_wdata, tb_write} = {rstsys_pkg::IDX_FORCE, 9'h03};
        default: go = 1'b1;
      endcase
      repeat (10)
      begin
        @(negedge mclk);
        {watchdog_timeout, illegal_opcode, stop_instruction} = 3'h0;
        {background_instruction, clock_generator_reset} = 2'h0;
        {tb_write, go} = 2'h0;
        if (system_reset === 1'b1)
        begin
          seen = 1'b1;
          {low_voltage_below, reset_terminal_n} = 2'h1;
        end
      end
      {low_voltage_below, reset_terminal_n} = 2'h1;
      check("reset taken", {7'h0, seen}, {7'h0, hit});
      if (hit)
      begin
        settle;
        rd(rstsys_pkg::IDX_STATUS, v);
        check("status", v, exp);
      end
    end
  endtask

  initial
  begin
    {fails, num_checks, cycles} = '0;
    {rst_n, tb_write, go, tb_index, tb_wdata, host_delay} = '0;
    {low_voltage_below, stop_mode, low_voltage_stop_enable} = 3'h0;
    {low_voltage_detect_enable, low_voltage_reset_enable} = 2'h3;
    {watchdog_timeout, illegal_opcode, stop_instruction} = 3'h0;
    {background_instruction, background_mode_enable} = 2'h0;
    {clock_generator_reset, reset_terminal_n} = 2'h1;
    watchdog_clock_select = 1'b1;
    por;
    rd(rstsys_pkg::IDX_STATUS, v);
    check("status por", v, 8'h82);
    rd(rstsys_pkg::IDX_FORCE, v);
    check("force read", v, 8'h00);
    opts(8'hC2);
    restart_chk(8'h82);
    fire(5, 1'b1, 8'h82);
    fire(0, 1'b1, 8'h20);
    fire(1, 1'b1, 8'h10);
    fire(2, 1'b1, 8'h10);
    fire(3, 1'b1, 8'h10);
    fire(4, 1'b1, 8'h04);
    fire(5, 1'b1, 8'h02);
    fire(7, 1'b0, 8'h00);
    low_voltage_reset_enable = 1'b0;
    fire(5, 1'b0, 8'h00);
    {low_voltage_reset_enable, stop_mode} = 2'h3;
    fire(5, 1'b0, 8'h00);
    {stop_mode, background_mode_enable} = 2'h1;
    fire(3, 1'b0, 8'h00);
    fire(6, 1'b0, 8'h00);
    wr(rstsys_pkg::IDX_OPTIONS, 8'h2D);
    opts(8'h21);
    wr(rstsys_pkg::IDX_OPTIONS, 8'hC2);
    opts(8'h21);
    fire(0, 1'b0, 8'h00);
    fire(2, 1'b0, 8'h00);
    fire(6, 1'b1, 8'h40);
    opts(8'hC3);
    restart_chk(8'h40);
    host_delay = 4'h3;
    fire(8, 1'b1, 8'h00);
    watchdog_clock_select = 1'b0;
    por;
    opts(8'hC2);
    wrap_up;
  end
endmodule
